// File: core/ptpc_top.sv
`timescale 1ns/1ps
`default_nettype none
module ptpc_top (
  // clock and reset
  input  wire logic                              ref_clk_i,
  input  wire logic                              reset_n_i,
  // transmit tap
  input  wire logic                              tx_clk_i,
  input  wire logic                              tx_en_i,
  input  wire logic [7:0]                        tx_d_i,
  output logic                                   tx_en_o,
  output logic [7:0]                             tx_d_o,
  // receive tap
  input  wire logic                              rx_clk_i,
  input  wire logic                              rx_dv_i,
  input  wire logic [7:0]                        rx_d_i,
  // tap configuration
  input  wire logic [2:0]                        speed_i,
  input  wire ptpc_pkg::ptpc_cfg_t [1:0]         cfg_i,
  input  wire logic [15:0]                       delay_100_i,
  input  wire logic [15:0]                       delay_1000_i,
  // timestamp fifos
  input  wire logic [ptpc_pkg::NFIFO-1:0]        fifo_pop_i,
  output ptpc_pkg::ptpc_entry_t [ptpc_pkg::NFIFO-1:0] fifo_head_o,
  output logic [ptpc_pkg::NFIFO-1:0][2:0]        fifo_level_o,
  // clock control
  input  wire logic [47:0]                       step_i,
  input  wire ptpc_pkg::ptpc_time_t              hold_i,
  input  wire logic                              load_time_i,
  input  wire logic                              add_offset_once_i,
  input  wire logic                              stop_clock_i,
  input  wire logic [1:0]                        snap_i,
  output ptpc_pkg::ptpc_time_t                   time_o,
  output ptpc_pkg::ptpc_time_t [1:0]             rd_time_o,
  // leap second
  input  wire logic                              leap_set_i,
  input  wire logic [15:0]                       leap_second_value_i,
  input  wire logic [31:0]                       leap_apply_instant_i,
  output logic [15:0]                            leap_cur_o,
  output logic [15:0]                            leap_new_o,
  // interrupts
  input  wire logic [ptpc_pkg::IRQ_W-1:0]        int_mask_i,
  input  wire logic                              int_clr_i,
  input  wire logic [ptpc_pkg::IRQ_W-1:0]        int_clr_data_i,
  output logic [ptpc_pkg::IRQ_W-1:0]             irq_src_o,
  output logic                                   irq_o
);
  import ptpc_pkg::*;

  typedef struct packed {
    logic [31:0]                                sec;
    logic [71:0]                                nsf;
    logic [31:0]                                stop;
    logic                                       ovf;
    ptpc_time_t [1:0]                           rd;
    logic [15:0]                                leap_cur;
    logic [15:0]                                leap_new;
    logic [31:0]                                leap_at;
    logic                                       leap_arm;
    ptpc_entry_t [NFIFO-1:0][FIFO_DEPTH-1:0]    mem;
    logic [NFIFO-1:0][2:0]                      cnt;
    logic [IRQ_W-1:0]                           src;
    logic                                       irq;
    ptpc_time_t                                 now_tx;
    ptpc_time_t                                 now_rx;
  } ptpc_top_s_t;

  ptpc_top_s_t               s;
  ptpc_top_s_t               n;
  logic [72:0]               acc;
  logic [15:0]               dly;
  logic                      pop;
  logic [IRQ_W-1:0]          ev;
  logic [IRQ_W-1:0]          clr;
  logic                      full_any;
  logic                      gig;
  ptpc_time_t                now;
  logic [NFIFO-1:0]          hit;
  ptpc_entry_t [NFIFO-1:0]   ent;
  logic [NFIFO-1:0]          tap_en;
  logic [NFIFO-1:0][7:0]     tap_d;

  assign gig = (speed_i == SPD_GMII);
  assign now = '{sec: s.sec, ns: s.nsf[71:40]};

  // fifo k: unit k/2, odd k transmit, even k receive
  for (genvar k = 0; k < NFIFO; k++) begin : g_tap
    if (k < 2 || UNIT1_EN) begin : g_on
      ptpc_tsu u_tsu (
        .ref_clk_i  (ref_clk_i),
        .reset_n_i  (reset_n_i),
        .link_clk_i ((k % 2 == 1) ? tx_clk_i : rx_clk_i),
        .link_en_i  ((k % 2 == 1) ? tx_en_i : rx_dv_i),
        .link_d_i   ((k % 2 == 1) ? tx_d_i : rx_d_i),
        .link_en_o  (tap_en[k]),
        .link_d_o   (tap_d[k]),
        .gig_i      (gig),
        .one_step_i ((k == 1) && cfg_i[0].one_step && ptpc_one_step_ok(speed_i)),
        .cfg_i      (cfg_i[k/2]),
        .now_i      ((k % 2 == 1) ? s.now_tx : s.now_rx),
        .hit_o      (hit[k]),
        .entry_o    (ent[k])
      );
    end else begin : g_off
      assign tap_en[k] = 1'b0;
      assign tap_d[k]  = 8'h00;
      assign hit[k]    = 1'b0;
      assign ent[k]    = '0;
    end
  end

  assign tx_en_o = tap_en[1];
  assign tx_d_o  = tap_d[1];

  always_comb begin
    n     = s;
    n.ovf = 1'b0;
    // time base
    acc = {1'b0, s.nsf} + ((s.stop != 32'h0) ? 73'h0 : {25'h0, step_i});
    if (add_offset_once_i) begin
      acc = acc + {1'b0, hold_i.ns, 40'h0};
    end
    if (acc[72:40] >= {1'b0, NS_WRAP}) begin
      acc[72:40]     = acc[72:40] - {1'b0, NS_WRAP};
      {n.ovf, n.sec} = {1'b0, s.sec} + 33'h1;
    end
    n.nsf = acc[71:0];
    if (s.stop != 32'h0) begin
      n.stop = s.stop - 32'h1;
    end
    if (stop_clock_i) begin
      n.stop = hold_i.ns;
    end
    if (load_time_i) begin
      n.sec  = hold_i.sec;
      n.nsf  = {hold_i.ns, 40'h0};
      n.ovf  = 1'b0;
      n.stop = 32'h0;
    end
    // leap second
    if (s.leap_arm && s.sec == s.leap_at) begin
      n.leap_cur = s.leap_new;
      n.leap_arm = 1'b0;
    end
    if (leap_set_i) begin
      n.leap_new = leap_second_value_i;
      n.leap_at  = leap_apply_instant_i;
      n.leap_arm = 1'b1;
    end
    // readout pairs
    for (int i = 0; i < 2; i++) begin
      if (snap_i[i]) begin
        n.rd[i] = now;
      end
    end
    // phy delay: transmit leaves later, receive arrived earlier
    dly      = gig ? delay_1000_i : delay_100_i;
    n.now_tx = ptpc_shift(now, dly, 1'b0);
    n.now_rx = ptpc_shift(now, dly, 1'b1);
    // timestamp fifos, full fifo drops the new entry
    pop = 1'b0;
    for (int k = 0; k < NFIFO; k++) begin
      pop = fifo_pop_i[k] && (s.cnt[k] != 3'h0);
      if (pop) begin
        for (int j = 0; j < FIFO_DEPTH - 1; j++) begin
          n.mem[k][j] = s.mem[k][j+1];
        end
        n.cnt[k] = s.cnt[k] - 3'h1;
      end
      if (hit[k] && (s.cnt[k] != FIFO_FULL || pop)) begin
        n.mem[k][n.cnt[k][1:0]] = ent[k];
        n.cnt[k] = n.cnt[k] + 3'h1;
      end
    end
    full_any = 1'b0;
    for (int k = 0; k < NFIFO; k++) begin
      full_any = full_any | (n.cnt[k] == FIFO_FULL);
    end
    // interrupt sources: set wins, clear refused while active
    ev           = '0;
    ev[IRQ_OVF]  = n.ovf;
    ev[IRQ_TS]   = |hit;
    ev[IRQ_FULL] = full_any;
    clr   = int_clr_i ? (~int_clr_data_i & ~ev) : '0;
    n.src = (s.src & ~clr) | ev;
    n.irq = |(n.src & int_mask_i);
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s     <= '0;
      s.src <= IRQ_SRC_RST;
    end else begin
      s <= n;
    end
  end

  assign fifo_level_o = s.cnt;
  assign time_o       = now;
  assign rd_time_o    = s.rd;
  assign leap_cur_o   = s.leap_cur;
  assign leap_new_o   = s.leap_new;
  assign irq_src_o    = s.src;
  assign irq_o        = s.irq;
  for (genvar k = 0; k < NFIFO; k++) begin : g_head
    assign fifo_head_o[k] = s.mem[k][0];
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  AST_STEP: assert property (
    (!load_time_i && !add_offset_once_i && s.stop == 32'h0 && s.nsf[71:40] < 32'h3b000000)
    |=> s.nsf == $past(s.nsf) + {24'h0, $past(step_i)})
    else $error("step not added");
  AST_LOAD: assert property (
    load_time_i |=> time_o.sec == $past(hold_i.sec) && time_o.ns == $past(hold_i.ns))
    else $error("time load failed");
  AST_STOP: assert property (
    (s.stop != 32'h0 && !load_time_i && !add_offset_once_i) |=> s.nsf == $past(s.nsf))
    else $error("clock moved while stopped");
  AST_ADD: assert property (
    (add_offset_once_i && !load_time_i && s.stop == 32'h0 && hold_i.ns < 32'h10000000 &&
     s.nsf[71:40] < 32'h10000000)
    |=> s.nsf[71:40] >= $past(s.nsf[71:40]) + $past(hold_i.ns))
    else $error("offset not added");
  AST_OVF: assert property (
    (s.sec == 32'hffffffff && !load_time_i) ##1 (s.sec == 32'h0) |-> s.src[IRQ_OVF])
    else $error("overflow not flagged");
  AST_IRQ: assert property (
    (|(s.src & int_mask_i) && !int_clr_i) |=> irq_o)
    else $error("irq dropped while enabled source set");
  AST_CLR_DENY: assert property (
    (int_clr_i && !int_clr_data_i[IRQ_FULL] && full_any) |=> irq_src_o[IRQ_FULL])
    else $error("clear accepted while fifo full");
  AST_PUSH: assert property (
    (hit[0] && s.cnt[0] < FIFO_FULL && !fifo_pop_i[0]) |=> fifo_level_o[0] == $past(s.cnt[0]) + 3'h1)
    else $error("timestamp not pushed");
  AST_LEAP: assert property (
    (s.leap_arm && s.sec == s.leap_at && !leap_set_i) |=> leap_cur_o == $past(s.leap_new) && !s.leap_arm)
    else $error("leap not applied");
endmodule // ptpc_top
`default_nettype wire

// File: core/ptpc_pkg.sv
// Behaviour
// - primary tap on tx and rx, MII/GMII
// - optional second tap unit, build-time enabled
// - rx always two-step; unit 1 tx two-step
// - unit 0 tx one-step insert at offsets
// - event on timestamp made or fifo full
// - packets selected by pattern under mask
// - match pushes 64-bit timestamp into fifo
// - per-unit control; fifo state reported
// - packet section stored with the timestamp
// - timestamps corrected by per-speed phy delay
// - up to four high-speed ports, one type; HS_PORTS is 0 and no port logic exists
// - one-step only up to 25 gigabit
// - each event gated by its mask bit
// - write zero clears; refused while active
// - irq held while any enabled bit set
// - 32 s, 32 ns, 32 frac, 8 ufrac
// - two independent time readout pairs
// - step added each cycle, max 255 ns
// - time loaded from holding seconds/nanoseconds
// - add-offset adds holding ns once
// - stop: zero step for holding-ns cycles
// - seconds overflow raises an event
// - leap value applied at apply instant
package ptpc_pkg;
  localparam int           CLK_PERIOD_NS = 10;
  localparam int           STEP_MAX_NS   = 255;
  localparam logic [31:0]  NS_WRAP       = 32'h3b9aca00;
  localparam logic [47:0]  STEP_RST      = 48'h0a0000000000;
  localparam bit           UNIT1_EN      = 1'b1;
  localparam int           HS_PORTS      = 0;
  localparam int           NFIFO         = 4;
  localparam int           FIFO_DEPTH    = 4;
  localparam logic [2:0]   FIFO_FULL     = 3'h4;
  localparam logic [7:0]   SFD           = 8'hd5;
  localparam int           IRQ_OVF       = 0;
  localparam int           IRQ_TS        = 1;
  localparam int           IRQ_FULL      = 2;
  localparam int           IRQ_W         = 3;
  localparam logic [2:0]   IRQ_SRC_RST   = 3'h0;
  localparam logic [2:0]   SPD_MII       = 3'h0;
  localparam logic [2:0]   SPD_GMII      = 3'h1;
  localparam logic [2:0]   SPD_10G       = 3'h2;
  localparam logic [2:0]   SPD_25G       = 3'h3;
  localparam logic [2:0]   SPD_40G       = 3'h4;
  localparam logic [2:0]   SPD_100G      = 3'h5;

  typedef enum logic [2:0] {
    TS_IDLE = 3'b001,
    TS_PRE  = 3'b010,
    TS_BODY = 3'b100
  } ptpc_tsst_t;

  typedef struct packed {
    logic [31:0] sec;
    logic [31:0] ns;
  } ptpc_time_t;

  typedef struct packed {
    logic        enable;
    logic        one_step;
    logic [31:0] pattern;
    logic [31:0] mask;
    logic [7:0]  match_off;
    logic [7:0]  ins_off;
    logic [7:0]  csum_off;
  } ptpc_cfg_t;

  typedef struct packed {
    ptpc_time_t  ts;
    logic [31:0] sect;
  } ptpc_entry_t;

  // high-speed ports beyond 25 gigabit are two-step only
  function automatic logic ptpc_one_step_ok(logic [2:0] spd);
    return spd <= SPD_25G;
  endfunction

  function automatic ptpc_time_t ptpc_shift(ptpc_time_t t, logic [15:0] d, logic sub);
    ptpc_time_t r;
    r = t;
    if (sub) begin
      if (t.ns < {16'h0, d}) begin
        r.ns  = t.ns + NS_WRAP - {16'h0, d};
        r.sec = t.sec - 32'h1;
      end else begin
        r.ns = t.ns - {16'h0, d};
      end
    end else begin
      r.ns = t.ns + {16'h0, d};
      if (r.ns >= NS_WRAP) begin
        r.ns  = r.ns - NS_WRAP;
        r.sec = t.sec + 32'h1;
      end
    end
    return r;
  endfunction
endpackage

// File: core/ptpc_tsu.sv
`timescale 1ns/1ps
`default_nettype none
module ptpc_tsu (
  // clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 reset_n_i,
  // link tap
  input  wire logic                 link_clk_i,
  input  wire logic                 link_en_i,
  input  wire logic [7:0]           link_d_i,
  output logic                      link_en_o,
  output logic [7:0]                link_d_o,
  // control
  input  wire logic                 gig_i,
  input  wire logic                 one_step_i,
  input  wire ptpc_pkg::ptpc_cfg_t  cfg_i,
  input  wire ptpc_pkg::ptpc_time_t now_i,
  // capture
  output logic                      hit_o,
  output ptpc_pkg::ptpc_entry_t     entry_o
);
  import ptpc_pkg::*;

  typedef struct packed {
    logic [2:0]  ck;
    logic [1:0]  en;
    logic [15:0] d;
    ptpc_tsst_t  st;
    logic        nib;
    logic [3:0]  low;
    logic [7:0]  idx;
    logic [31:0] win;
    ptpc_time_t  ts;
    logic        done;
    logic        en_o;
    logic [7:0]  d_o;
    logic        hit;
    ptpc_entry_t ent;
  } ptpc_tsu_s_t;

  ptpc_tsu_s_t s;
  ptpc_tsu_s_t n;
  logic        fe;
  logic        bok;
  logic        ins;
  logic        csm;
  logic [7:0]  b;
  logic [7:0]  rb;
  logic [8:0]  pos;

  always_comb begin
    n      = s;
    n.ck   = {s.ck[1:0], link_clk_i};
    n.en   = {s.en[0], link_en_i};
    n.d    = {s.d[7:0], link_d_i};
    n.hit  = 1'b0;
    // data is stable at the falling link edge
    fe     = s.ck[2] & ~s.ck[1];
    b      = gig_i ? s.d[15:8] : {s.d[11:8], s.low};
    bok    = gig_i | s.nib;
    pos    = {1'b0, s.idx} - {1'b0, cfg_i.ins_off};
    ins    = one_step_i && (s.st == TS_BODY) && (pos < 9'h8);
    csm    = one_step_i && (s.st == TS_BODY) &&
             (s.idx == cfg_i.csum_off || s.idx == cfg_i.csum_off + 8'h1);
    rb     = csm ? 8'h00 : 8'(s.ts >> {3'h7 - pos[2:0], 3'h0});
    if (fe) begin
      n.en_o = s.en[1];
      if (ins || csm) begin
        n.d_o = gig_i ? rb : {4'h0, s.nib ? rb[7:4] : rb[3:0]};
      end else begin
        n.d_o = gig_i ? s.d[15:8] : {4'h0, s.d[11:8]};
      end
      if (!s.en[1]) begin
        n.st  = TS_IDLE;
        n.nib = 1'b0;
      end else begin
        unique case (s.st)
          TS_IDLE: n.st = TS_PRE;
          TS_PRE: begin
            if (gig_i ? (s.d[15:8] == SFD) : (s.d[11:8] == SFD[7:4])) begin
              n.st   = TS_BODY;
              n.ts   = now_i;
              n.idx  = 8'h00;
              n.nib  = 1'b0;
              n.done = 1'b0;
            end
          end
          TS_BODY: begin
            n.nib = ~s.nib & ~gig_i;
            n.low = s.d[11:8];
            if (bok) begin
              n.win = {s.win[23:0], b};
              if (s.idx != 8'hff) begin
                n.idx = s.idx + 8'h1;
              end
              if (!s.done && s.idx == cfg_i.match_off + 8'h3) begin
                n.done     = 1'b1;
                n.hit      = cfg_i.enable && (((n.win ^ cfg_i.pattern) & cfg_i.mask) == 32'h0);
                n.ent.ts   = s.ts;
                n.ent.sect = n.win;
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s    <= '0;
      s.st <= TS_IDLE;
    end else begin
      s <= n;
    end
  end

  assign link_en_o = s.en_o;
  assign link_d_o  = s.d_o;
  assign hit_o     = s.hit;
  assign entry_o   = s.ent;

  AST_HIT_CAUSE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    hit_o |-> $past(cfg_i.enable) && $past(s.st == TS_BODY) && $past(fe))
    else $error("capture without enabled match");
  AST_SFD_TS: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (s.st == TS_PRE) ##1 (s.st == TS_BODY) |-> s.ts == $past(now_i))
    else $error("timestamp not taken at sfd");
endmodule // ptpc_tsu
`default_nettype wire

// File: verif/ptpc_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module ptpc_link_model (
  // link side
  output logic       lclk_o,
  output logic       en_o,
  output logic [7:0] d_o
);
  initial begin
    lclk_o = 1'b0;
    en_o   = 1'b0;
    d_o    = 8'h00;
  end

  // one link cycle; data moves just after the rising edge
  task automatic cyc(input logic e, input logic [7:0] v);
    lclk_o = 1'b1;
    #1;
    en_o = e;
    d_o  = v;
    #39;
    lclk_o = 1'b0;
    #40;
  endtask

  // preamble, delimiter, 12 body bytes i*17; byte 2 from the caller
  task automatic send(input bit mii, input logic [7:0] b2);
    logic [7:0] b;
    for (int i = -8; i < 14; i++) begin
      b = (i < -1) ? 8'h55 : (i == -1) ? 8'hd5 : (i == 2) ? b2 : 8'(i * 17);
      if (i >= 12) cyc(1'b0, ~d_o);
      else if (mii) begin
        cyc(1'b1, {~b[3:0], b[3:0]});
        cyc(1'b1, {~b[7:4], b[7:4]});
      end else cyc(1'b1, b);
    end
  endtask
endmodule // ptpc_link_model
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ptpc_pkg::*;
  logic                    clk, rst_n, tclk, ten, rclk, rdv, txeo, tx_seen;
  logic [7:0]              td, rd, txdo, lat8;
  logic [2:0]              spd, msk, cdat, src;
  ptpc_cfg_t [1:0]         cfg;
  logic [15:0]             d100, d1000, lval, lcur, lnew;
  logic [3:0]              pop;
  ptpc_entry_t [3:0]       head;
  logic [3:0][2:0]         lvl;
  logic [47:0]             step;
  ptpc_time_t              hold, tnow;
  ptpc_time_t [1:0]        rdt;
  logic                    ld, add, stp, lset, clr, irq;
  logic [1:0]              snap;
  logic [31:0]             lat;
  int                      err_total, tests_run, cyc_n;

  ptpc_link_model u_mac (.lclk_o(tclk), .en_o(ten), .d_o(td));
  ptpc_link_model u_phy (.lclk_o(rclk), .en_o(rdv), .d_o(rd));

  ptpc_top u_dut (
    .ref_clk_i(clk), .reset_n_i(rst_n),
    .tx_clk_i(tclk), .tx_en_i(ten), .tx_d_i(td), .tx_en_o(txeo), .tx_d_o(txdo),
    .rx_clk_i(rclk), .rx_dv_i(rdv), .rx_d_i(rd),
    .speed_i(spd), .cfg_i(cfg), .delay_100_i(d100), .delay_1000_i(d1000),
    .fifo_pop_i(pop), .fifo_head_o(head), .fifo_level_o(lvl),
    .step_i(step), .hold_i(hold), .load_time_i(ld), .add_offset_once_i(add),
    .stop_clock_i(stp), .snap_i(snap), .time_o(tnow), .rd_time_o(rdt),
    .leap_set_i(lset), .leap_second_value_i(lval), .leap_apply_instant_i(lat),
    .leap_cur_o(lcur), .leap_new_o(lnew),
    .int_mask_i(msk), .int_clr_i(clr), .int_clr_data_i(cdat), .irq_src_o(src),
    .irq_o(irq)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (txeo === 1'b1) tx_seen <= 1'b1;
    cyc_n++;
    if (cyc_n == 20000) begin
      err_total++;
      $display("Error cycle limit expected %0d seen %0d", 19999, cyc_n);
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic load(input logic [31:0] s, input logic [31:0] n);
    @(posedge clk);
    hold <= '{s, n};
    ld   <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    #1;
  endtask

  task automatic clear(input logic [2:0] v);
    @(posedge clk);
    clr  <= 1'b1;
    cdat <= v;
    @(posedge clk);
    clr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic wait_lvl(input int k, input logic [2:0] v);
    int n;
    n = 0;
    while (lvl[k] !== v && n < 400) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    #1;
    chk("fifo level", v, lvl[k]);
  endtask

  task automatic t_clock;
    ptpc_time_t a;
    load(32'h5, 32'h64);
    chk("load", {32'h5, 32'h64}, tnow);
    @(posedge clk);
    #1;
    chk("step", {32'h5, 32'h6e}, tnow);
    @(posedge clk);
    hold <= '{32'h0, 32'h3e8};
    add  <= 1'b1;
    #1;
    a = tnow;
    @(posedge clk);
    add <= 1'b0;
    #1;
    chk("add offset", {a.sec, a.ns + 32'h3f2}, tnow);
    @(posedge clk);
    hold <= '{32'h0, 32'h5};
    stp  <= 1'b1;
    @(posedge clk);
    stp <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    a = tnow;
    repeat (3) @(posedge clk);
    #1;
    chk("stopped", a, tnow);
    @(posedge clk);
    #1;
    chk("resumed", {a.sec, a.ns + 32'ha}, tnow);
    $display("t_clock done");
  endtask

  task automatic t_irq;
    load(32'hffffffff, NS_WRAP - 32'h14);
    repeat (3) @(posedge clk);
    #1;
    chk("wrap", {32'h0, 32'ha}, tnow);
    repeat (2) @(posedge clk);
    #1;
    chk("ovf src", 1'b1, src[IRQ_OVF]);
    chk("masked irq", 1'b0, irq);
    @(posedge clk);
    msk <= 3'h1;
    repeat (2) @(posedge clk);
    #1;
    chk("irq on", 1'b1, irq);
    clear(3'b110);
    chk("ovf clear", {3'h0, 1'b0}, {src, irq});
    @(posedge clk);
    lval <= 16'h25;
    lat  <= 32'h1;
    lset <= 1'b1;
    @(posedge clk);
    lset <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("leap new", 16'h25, lnew);
    chk("leap early", 16'h0, lcur);
    load(32'h0, NS_WRAP - 32'h32);
    repeat (10) @(posedge clk);
    #1;
    chk("leap applied", 16'h25, lcur);
    $display("t_irq done");
  endtask

  task automatic t_frame;
    ptpc_time_t f;
    load(32'h10, 32'h1000);
    @(posedge clk);
    hold <= '{32'h0, 32'h3e8};
    stp  <= 1'b1;
    @(posedge clk);
    stp <= 1'b0;
    repeat (2) @(posedge clk);
    snap <= 2'b11;
    @(posedge clk);
    snap <= 2'b00;
    #1;
    f = tnow;
    @(posedge clk);
    #1;
    chk("snap 0", f, rdt[0]);
    chk("snap 1", f, rdt[1]);
    u_mac.send(1'b0, 8'h22);
    wait_lvl(1, 3'h1);
    chk("tx stamp", {f.sec, f.ns + 32'(d1000)}, head[1].ts);
    chk("tx section", 32'h22334455, head[1].sect);
    chk("u1 tx level", 3'h1, lvl[3]);
    chk("tx stream", 1'b1, tx_seen);
    @(posedge clk);
    spd <= SPD_MII;
    u_phy.send(1'b1, 8'h22);
    wait_lvl(0, 3'h1);
    chk("rx stamp", {f.sec, f.ns - 32'(d100)}, head[0].ts);
    chk("u1 rx level", 3'h1, lvl[2]);
    chk("ts src", 3'h2, src);
    repeat (600) @(posedge clk);
    $display("t_frame done");
  endtask

  task automatic t_full;
    @(posedge clk);
    pop           <= 4'hf;
    cfg[1].enable <= 1'b0;
    spd           <= SPD_GMII;
    msk           <= 3'h7;
    @(posedge clk);
    pop <= 4'h0;
    u_mac.send(1'b0, 8'h99);
    wait_lvl(1, 3'h0);
    for (int i = 1; i <= 5; i++) begin
      u_mac.send(1'b0, 8'h22);
      wait_lvl(1, (i > 4) ? FIFO_FULL : 3'(i));
    end
    chk("u1 disabled", 3'h0, lvl[3]);
    chk("full src", {1'b1, 1'b1}, {src[IRQ_FULL], irq});
    clear(3'b011);
    chk("clear refused", 1'b1, src[IRQ_FULL]);
    @(posedge clk);
    pop <= 4'h2;
    @(posedge clk);
    pop <= 4'h0;
    clear(3'b001);
    chk("cleared", {3'h0, 1'b0}, {src, irq});
    $display("t_full done");
  endtask

  initial begin
    rst_n   = 1'b0;
    tx_seen = 1'b0;
    spd     = SPD_GMII;
    cfg[0]  = '{1'b1, 1'b1, 32'h22334455, 32'hffffffff, 8'h02, 8'h30, 8'h32};
    cfg[1]  = '{1'b1, 1'b0, 32'h22330000, 32'hffff0000, 8'h02, 8'h30, 8'h32};
    d100    = 16'h0020;
    d1000   = 16'h0040;
    pop     = 4'h0;
    step    = STEP_RST;
    hold    = '0;
    {ld, add, stp, lset, clr} = 5'h0;
    snap    = 2'b00;
    lval    = 16'h0;
    lat     = 32'h0;
    lat8    = 8'h0;
    msk     = 3'h0;
    cdat    = 3'h7;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_clock;
    t_irq;
    t_frame;
    t_full;
    conclude();
  end
endmodule // tb_top
`default_nettype wire
